// >>> hw/emw_consts.svh
`ifndef EMW_CONSTS_SVH
`define EMW_CONSTS_SVH
`define EMW_OFF_LABEL     8'hDC
`define EMW_OFF_ADDR_LO   8'hE0
`define EMW_OFF_ADDR_HI   8'hE4
`define EMW_OFF_PAYLOAD   8'hE8
`define EMW_OFF_ATTR      8'hEC
`define EMW_OFF_ECR       8'hF0
`define EMW_ATTR_MASK     32'h3F00_0001
`define EMW_LABEL_MASK    32'h00FF_FFFF
`define EMW_ADHI_MASK     32'h000F_FFFF
`define EMW_ADLO_MASK     32'hFFFF_FFFC
`define EMW_ECR_MASK      32'h0000_0001
`define EMW_SH_LO         28
`define EMW_MT_LO         24
`define EMW_EN_BIT        0
`define EMW_SH_OUTER      2'h2
`define EMW_MT_DEV_STRICT 4'h0
`endif

// >>> hw/emw_pkg.sv
`default_nettype none
package emw_pkg;
   typedef struct packed {
      logic [51:0] addr;
      logic [31:0] payload;
      logic [15:0] partition_identifier;
      logic [7:0]  monitoring_group;
      logic        secure;
      logic [3:0]  msg_memory_type;
      logic [1:0]  msg_shareability;
   } emw_msg_t;
   typedef struct packed {
      logic [31:0] label;
      logic [31:0] addr_lo;
      logic [31:0] addr_hi;
      logic [31:0] payload;
      logic [31:0] attr;
      logic [31:0] ecr;
   } emw_bank_t;
   typedef enum logic [2:0] {
      EMW_IDLE = 3'b001,
      EMW_SEND = 3'b010,
      EMW_WAIT = 3'b100
   } emw_state_t;
endpackage : emw_pkg
`default_nettype wire

// >>> hw/emw_error_msi.sv
`include "emw_consts.svh"
`default_nettype none
module emw_error_msi
   import emw_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire  logic              mclk,
   input  wire  logic              rst_n,
   input  wire  logic              err_msg_capability,
   input  wire  logic              reg_sel,
   input  wire  logic              reg_secure,
   input  wire  logic              reg_write,
   input  wire  logic [ADDR_W-1:0] reg_addr,
   input  wire  logic [31:0]       reg_wdata,
   output var   logic [31:0]       reg_rdata,
   output var   logic              reg_ack,
   input  wire  logic              err_new_secure,
   input  wire  logic              err_new_nonsecure,
   output var   logic              msg_valid,
   input  wire  logic              msg_ready,
   output var   emw_msg_t          msg,
   output var   logic              err_irq_secure,
   output var   logic              err_irq_nonsecure
);

   initial begin
      if (ADDR_W < 8) $error("ADDR_W must be at least 8");
   end

   // ------------------------------------------------------------
   // register banks, index 1 secure, 0 non-secure
   // ------------------------------------------------------------
   emw_bank_t bank_q [2];
   emw_bank_t bank_d [2];
   logic [31:0] rdata_d;
   logic        ack_d;

   function automatic logic [31:0] emw_mask(input logic [ADDR_W-1:0] a,
                                            input logic              cap);
      logic [31:0] m;
      m = 32'h0000_0000;
      if (a == ADDR_W'(`EMW_OFF_ECR)) begin
         m = `EMW_ECR_MASK;
      end else if (!cap) begin
         m = 32'h0000_0000;
      end else if (a == ADDR_W'(`EMW_OFF_LABEL)) begin
         m = `EMW_LABEL_MASK;
      end else if (a == ADDR_W'(`EMW_OFF_ADDR_LO)) begin
         m = `EMW_ADLO_MASK;
      end else if (a == ADDR_W'(`EMW_OFF_ADDR_HI)) begin
         m = `EMW_ADHI_MASK;
      end else if (a == ADDR_W'(`EMW_OFF_PAYLOAD)) begin
         m = 32'hFFFF_FFFF;
      end else if (a == ADDR_W'(`EMW_OFF_ATTR)) begin
         m = `EMW_ATTR_MASK;
      end
      return m;
   endfunction : emw_mask

   always_comb begin
      logic [31:0] m;
      logic        s;
      m = emw_mask(reg_addr, err_msg_capability);
      s = reg_secure;
      bank_d[0] = bank_q[0];
      bank_d[1] = bank_q[1];
      rdata_d   = 32'h0000_0000;
      ack_d     = reg_sel;
      if (reg_sel && reg_write) begin
         if (reg_addr == ADDR_W'(`EMW_OFF_LABEL)) begin
            bank_d[s].label = reg_wdata & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_ADDR_LO)) begin
            bank_d[s].addr_lo = reg_wdata & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_ADDR_HI)) begin
            bank_d[s].addr_hi = reg_wdata & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_PAYLOAD)) begin
            bank_d[s].payload = reg_wdata & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_ATTR)) begin
            bank_d[s].attr = reg_wdata & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_ECR)) begin
            bank_d[s].ecr = reg_wdata & m;
         end
      end else if (reg_sel) begin
         if (reg_addr == ADDR_W'(`EMW_OFF_LABEL)) begin
            rdata_d = bank_q[s].label & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_ADDR_LO)) begin
            rdata_d = bank_q[s].addr_lo & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_ADDR_HI)) begin
            rdata_d = bank_q[s].addr_hi & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_PAYLOAD)) begin
            rdata_d = bank_q[s].payload & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_ATTR)) begin
            rdata_d = bank_q[s].attr & m;
         end else if (reg_addr == ADDR_W'(`EMW_OFF_ECR)) begin
            rdata_d = bank_q[s].ecr & m;
         end
      end
      if (!err_msg_capability) begin
         bank_d[0].attr = 32'h0000_0000;
         bank_d[1].attr = 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // message issue
   // ------------------------------------------------------------
   emw_state_t  state_q, state_d;
   logic [1:0]  pend_q, pend_d;
   emw_msg_t    msg_q, msg_d;
   logic        valid_q, valid_d;
   logic        irq_s_q, irq_s_d;
   logic        irq_ns_q, irq_ns_d;

   function automatic emw_msg_t emw_build(input emw_bank_t b, input logic sec);
      emw_msg_t    r;
      logic [3:0]  mt;
      logic        dev;
      mt  = b.attr[`EMW_MT_LO +: 4];
      // any code with a zero half is device; reserved ones collapse to strictest
      dev = (mt[3:2] == 2'h0) || (mt[1:0] == 2'h0);
      r.addr = {b.addr_hi[19:0], b.addr_lo[31:2], 2'h0};
      r.payload = b.payload;
      r.partition_identifier = b.label[15:0];
      r.monitoring_group = b.label[23:16];
      r.secure = sec;
      if (dev && mt[3:2] != 2'h0) begin
         r.msg_memory_type = `EMW_MT_DEV_STRICT;
      end else begin
         r.msg_memory_type = mt;
      end
      if (dev) begin
         r.msg_shareability = `EMW_SH_OUTER;
      end else begin
         r.msg_shareability = b.attr[`EMW_SH_LO +: 2];
      end
      return r;
   endfunction : emw_build

   always_comb begin
      logic [1:0] fire;
      logic [1:0] en;
      logic [1:0] msi;
      en[1]  = bank_q[1].ecr[`EMW_EN_BIT];
      en[0]  = bank_q[0].ecr[`EMW_EN_BIT];
      msi[1] = bank_q[1].attr[`EMW_EN_BIT] & err_msg_capability;
      msi[0] = bank_q[0].attr[`EMW_EN_BIT] & err_msg_capability;
      fire   = {err_new_secure, err_new_nonsecure} & en;
      pend_d   = pend_q | (fire & msi);
      state_d  = state_q;
      msg_d    = msg_q;
      valid_d  = valid_q;
      irq_s_d  = fire[1] & ~msi[1];
      irq_ns_d = fire[0] & ~msi[0];
      case (state_q)
         EMW_IDLE: begin
            if (pend_q[1]) begin
               msg_d     = emw_build(bank_q[1], 1'b1);
               pend_d[1] = fire[1] & msi[1];
               valid_d   = 1'b1;
               state_d   = EMW_SEND;
            end else if (pend_q[0]) begin
               msg_d     = emw_build(bank_q[0], 1'b0);
               pend_d[0] = fire[0] & msi[0];
               valid_d   = 1'b1;
               state_d   = EMW_SEND;
            end
         end
         EMW_SEND: begin
            if (msg_ready) begin
               valid_d = 1'b0;
               state_d = EMW_WAIT;
            end
         end
         EMW_WAIT: begin
            state_d = EMW_IDLE;
         end
         default: begin
            state_d = EMW_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         // label and data left alone: undefined after warm reset
         bank_q[0].attr <= 32'h0000_0000;
         bank_q[1].attr <= 32'h0000_0000;
         bank_q[0].ecr  <= 32'h0000_0000;
         bank_q[1].ecr  <= 32'h0000_0000;
         state_q   <= EMW_IDLE;
         pend_q    <= 2'h0;
         valid_q   <= 1'b0;
         msg_q     <= '0;
         irq_s_q   <= 1'b0;
         irq_ns_q  <= 1'b0;
         reg_rdata <= 32'h0000_0000;
         reg_ack   <= 1'b0;
      end else begin
         bank_q[0].attr <= bank_d[0].attr;
         bank_q[1].attr <= bank_d[1].attr;
         bank_q[0].ecr  <= bank_d[0].ecr;
         bank_q[1].ecr  <= bank_d[1].ecr;
         state_q   <= state_d;
         pend_q    <= pend_d;
         valid_q   <= valid_d;
         msg_q     <= msg_d;
         irq_s_q   <= irq_s_d;
         irq_ns_q  <= irq_ns_d;
         reg_rdata <= rdata_d;
         reg_ack   <= ack_d;
      end
   end

   always_ff @(posedge mclk) begin
      bank_q[0].label   <= bank_d[0].label;
      bank_q[1].label   <= bank_d[1].label;
      bank_q[0].addr_lo <= bank_d[0].addr_lo;
      bank_q[1].addr_lo <= bank_d[1].addr_lo;
      bank_q[0].addr_hi <= bank_d[0].addr_hi;
      bank_q[1].addr_hi <= bank_d[1].addr_hi;
      bank_q[0].payload <= bank_d[0].payload;
      bank_q[1].payload <= bank_d[1].payload;
   end

   always_comb begin
      msg_valid         = valid_q;
      msg               = msg_q;
      err_irq_secure    = irq_s_q;
      err_irq_nonsecure = irq_ns_q;
   end

endmodule : emw_error_msi
`default_nettype wire

// >>> testbench/emw_itu_model.sv
`default_nettype none
module emw_itu_model
   import emw_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       msg_valid,
   input  wire emw_msg_t   msg,
   input  wire logic [1:0] stall,
   output var  logic       msg_ready,
   output var  emw_msg_t   got,
   output var  int         n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] w;
   // ---------------------------------------
   // translation unit: takes after stall waits
   // ---------------------------------------
   assign msg_ready = msg_valid && (w == stall);
   always @(posedge mclk) begin
      if (!rst_n) begin
         w <= 2'h0;
         n <= 0;
      end else if (msg_valid && msg_ready) begin
         w <= 2'h0;
         got <= msg;
         n <= n + 1;
      end else if (msg_valid) begin
         w <= w + 2'h1;
      end
   end
endmodule : emw_itu_model
`default_nettype wire

// >>> testbench/emw_error_msi_chk.sv
`default_nettype none
module emw_error_msi_chk
   import emw_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        reg_sel,
   input wire logic        reg_ack,
   input wire logic [31:0] reg_rdata,
   input wire logic        err_new_secure,
   input wire logic        err_new_nonsecure,
   input wire logic        msg_valid,
   input wire logic        msg_ready,
   input wire emw_msg_t    msg,
   input wire logic        err_irq_secure,
   input wire logic        err_irq_nonsecure
);
   // ---------------------------------------
   // port relations
   // ---------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_stall;
      msg_valid && !msg_ready;
   endsequence
   sequence s_dev;
      msg_valid && (msg.msg_memory_type[3:2] == 2'h0 || msg.msg_memory_type[1:0] == 2'h0);
   endsequence
   chk_ack_after_sel: assert property (reg_sel |=> reg_ack)
      else $error("ack missing");
   chk_ack_has_cause: assert property (reg_ack |-> $past(reg_sel))
      else $error("stray ack");
   chk_rdata_idle: assert property (!reg_ack |-> reg_rdata == 32'h0)
      else $error("rdata not zero");
   chk_offer_holds: assert property (s_stall |=> msg_valid && $stable(msg))
      else $error("offer dropped");
   chk_dev_outer: assert property (s_dev |-> msg.msg_shareability == 2'h2)
      else $error("device not outer");
   chk_resv_strict: assert property (s_dev |-> msg.msg_memory_type[3:2] == 2'h0)
      else $error("reserved type issued");
   chk_addr_align: assert property (msg_valid |-> msg.addr[1:0] == 2'h0)
      else $error("address unaligned");
   chk_irq_cause_s: assert property (err_irq_secure |-> $past(err_new_secure))
      else $error("stray secure irq");
   chk_irq_cause_ns: assert property (err_irq_nonsecure |-> $past(err_new_nonsecure))
      else $error("stray irq");
   chk_reset_idle: assert property ($rose(rst_n) |-> !msg_valid && !reg_ack)
      else $error("busy after reset");
endmodule : emw_error_msi_chk
bind emw_error_msi emw_error_msi_chk u_chk (.mclk(mclk), .rst_n(rst_n), .reg_sel(reg_sel),
   .reg_ack(reg_ack), .reg_rdata(reg_rdata), .err_new_secure(err_new_secure),
   .err_new_nonsecure(err_new_nonsecure), .msg_valid(msg_valid), .msg_ready(msg_ready),
   .msg(msg), .err_irq_secure(err_irq_secure), .err_irq_nonsecure(err_irq_nonsecure));
`default_nettype wire

// >>> testbench/testbench.sv
`include "emw_consts.svh"
`default_nettype none
module testbench
   import emw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, rst_n, cap, sel, sec, we, ens, enn, irq_s, irq_n, ack, mv, mr, irq;
   logic [7:0]  addr;
   logic [31:0] wd, rd;
   logic [1:0]  st;
   emw_msg_t    msg, got;
   int          n, fail_count, cmp_count;
   logic [31:0] lbl [2] = '{32'hFFA5_5A0F, 32'hFF12_3456};
   logic [31:0] pay [2] = '{32'h0BAD_F00D, 32'hDEAD_BEEF};
   logic [31:0] alo [2] = '{32'h8765_4323, 32'h1234_567F};
   logic [31:0] ahi [2] = '{32'hF001_2345, 32'hFFFA_BCDE};
   logic [3:0]  mts [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC, 4'h5, 4'hA, 4'hF};
   emw_error_msi u_dut (.mclk(mclk), .rst_n(rst_n), .err_msg_capability(cap), .reg_sel(sel),
      .reg_secure(sec), .reg_write(we), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rd),
      .reg_ack(ack), .err_new_secure(ens), .err_new_nonsecure(enn), .msg_valid(mv),
      .msg_ready(mr), .msg(msg), .err_irq_secure(irq_s), .err_irq_nonsecure(irq_n));
   emw_itu_model u_itu (.mclk(mclk), .rst_n(rst_n), .msg_valid(mv), .msg(msg), .stall(st),
      .msg_ready(mr), .got(got), .n(n));
   // ---------------------------------------
   // access tasks
   // ---------------------------------------
   task automatic chk(input string nm, input logic [127:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   task automatic acc(input logic s, w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {sel, sec, we, addr, wd} <= {1'b1, s, w, a, d};
      @(posedge mclk);
      sel <= 1'b0;
      #1;
   endtask : acc
   task automatic err(input logic s, input logic [1:0] sw, output logic q);
      int k0;
      k0 = n;
      @(posedge mclk);
      {st, ens, enn} <= {sw, s, !s};
      @(posedge mclk);
      {ens, enn} <= 2'b00;
      #1;
      q = s ? irq_s : irq_n;
      for (int i = 0; i < 12 && n == k0; i++) @(posedge mclk);
      repeat (3) @(posedge mclk);
   endtask : err
   function automatic emw_msg_t ex(input logic s, input logic [3:0] mt, input logic [1:0] sh);
      logic d;
      d = (mt[3:2] == 2'h0) || (mt[1:0] == 2'h0);
      ex = {ahi[s][19:0], alo[s][31:2], 2'h0, pay[s], lbl[s][15:0], lbl[s][23:16], s,
            (mt[1:0] == 2'h0) ? 4'h0 : mt, d ? 2'h2 : sh};
   endfunction : ex
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #20us;
      fail_count++;
      end_of_test();
   end
   // ---------------------------------------
   // tests
   // ---------------------------------------
   initial begin
      {rst_n, cap, sel, sec, we, ens, enn, addr, wd, st} = '0;
      cap = 1'b1;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      acc(1'b1, 1'b0, `EMW_OFF_ATTR, 32'h0);
      chk("attr_s", rd, 32'h0);
      acc(1'b0, 1'b0, `EMW_OFF_ATTR, 32'h0);
      chk("attr_ns", rd, 32'h0);
      for (int s = 0; s < 2; s++) begin
         acc(s[0], 1'b1, `EMW_OFF_LABEL, lbl[s]);
         acc(s[0], 1'b1, `EMW_OFF_ADDR_LO, alo[s]);
         acc(s[0], 1'b1, `EMW_OFF_ADDR_HI, ahi[s]);
         acc(s[0], 1'b1, `EMW_OFF_PAYLOAD, pay[s]);
         acc(s[0], 1'b1, `EMW_OFF_ECR, 32'h1);
      end
      for (int s = 0; s < 2; s++) begin
         acc(s[0], 1'b0, `EMW_OFF_LABEL, 32'h0);
         chk("label", rd, lbl[s] & `EMW_LABEL_MASK);
         acc(s[0], 1'b0, `EMW_OFF_ADDR_LO, 32'h0);
         chk("addr_lo", rd, alo[s] & `EMW_ADLO_MASK);
         acc(s[0], 1'b0, `EMW_OFF_ADDR_HI, 32'h0);
         chk("addr_hi", rd, ahi[s] & `EMW_ADHI_MASK);
         acc(s[0], 1'b0, `EMW_OFF_PAYLOAD, 32'h0);
         chk("payload", rd, pay[s]);
      end
      acc(1'b1, 1'b0, 8'h00, 32'h0);
      chk("unmapped", rd, 32'h0);
      acc(1'b1, 1'b1, `EMW_OFF_ATTR, 32'hFFFF_FFFF);
      acc(1'b1, 1'b0, `EMW_OFF_ATTR, 32'h0);
      chk("attr_mask", rd, `EMW_ATTR_MASK);
      $display("test registers done");
      foreach (mts[i]) begin
         acc(1'b1, 1'b1, `EMW_OFF_ATTR, {2'h0, 2'h3, mts[i], 23'h0, 1'b1});
         err(1'b1, i[1:0], irq);
         chk("msg_s", got, ex(1'b1, mts[i], 2'h3));
         chk("irq_s", irq, 1'b0);
      end
      for (int h = 0; h < 4; h++) begin
         acc(1'b0, 1'b1, `EMW_OFF_ATTR, {2'h0, h[1:0], 4'h7, 23'h0, 1'b1});
         err(1'b0, 2'h3 - h[1:0], irq);
         chk("msg_ns", got, ex(1'b0, 4'h7, h[1:0]));
      end
      $display("test messages done");
      acc(1'b1, 1'b1, `EMW_OFF_ATTR, 32'h0);
      err(1'b1, 2'h0, irq);
      chk("irq_line", irq, 1'b1);
      acc(1'b0, 1'b1, `EMW_OFF_ECR, 32'h0);
      err(1'b0, 2'h0, irq);
      chk("irq_off", irq, 1'b0);
      chk("msg_count", n, 14);
      cap <= 1'b0;
      acc(1'b1, 1'b0, `EMW_OFF_LABEL, 32'h0);
      chk("no_cap", rd, 32'h0);
      cap <= 1'b1;
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      acc(1'b0, 1'b0, `EMW_OFF_ATTR, 32'h0);
      chk("attr_rst", rd, 32'h0);
      $display("test enable and reset done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
